// ==== dv/uss_chk.sv ====
// Port checker of the universal shift unit
`default_nettype none
module uss_chk #(
  parameter int DATA_W = 8,
  parameter int CNT_W  = 4
) (
  input wire logic                 i_clk_sys,
  input wire logic                 i_srst,
  input wire logic                 i_timer0_match,
  input wire logic                 i_data_wr,
  input wire logic [DATA_W-1:0]    i_data_wdata,
  input wire logic                 i_status_wr,
  input wire uss_pkg::uss_status_t i_status_wdata,
  input wire logic                 i_control_wr,
  input wire uss_pkg::uss_ctrl_t   i_control_wdata,
  input wire logic                 i_overflow_irq_en,
  input wire logic [DATA_W-1:0]    o_shift_data,
  input wire logic [CNT_W-1:0]     o_counter,
  input wire logic                 o_counter_overflow_flag,
  input wire uss_pkg::uss_ctrl_t   o_control,
  input wire logic                 o_data_out,
  input wire logic                 o_serial_clock_level,
  input wire logic                 o_overflow_irq
);
  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_reset_clear: assert property ($fell(i_srst) |-> o_shift_data == '0
    && o_counter == '0 && !o_counter_overflow_flag && o_control == '0 && !o_data_out)
    else $error("state not clear after reset");
  a_data_load: assert property (i_data_wr |=> o_shift_data == $past(i_data_wdata))
    else $error("shift data not loaded");
  a_status_load: assert property (i_status_wr |=> o_counter == $past(i_status_wdata.count))
    else $error("count not loaded");
  a_status_clear: assert property (i_status_wr && i_status_wdata.counter_overflow_flag
    && i_status_wdata.count == '0 && o_counter != uss_pkg::CNT_MAX
    |=> !o_counter_overflow_flag && o_counter == '0) else $error("flag not cleared");
  a_timer_count: assert property (i_timer0_match && !o_control.external_clock_select
    && o_control.clock_polarity_select && !i_status_wr && !i_control_wr
    |=> o_counter == $past(o_counter) + uss_pkg::CNT_ONE
    && ($past(o_counter) != uss_pkg::CNT_MAX || o_counter_overflow_flag))
    else $error("timer match miscounted");
  a_quiet_count: assert property (!i_status_wr && !i_timer0_match && !i_control_wr
    && !o_control.external_clock_select && !o_control.clock_polarity_select
    |=> $stable(o_counter)) else $error("count moved without a clock");
  a_ctrl_back: assert property (i_control_wr |=> o_control[1:0] == 2'h0
    && o_control[5:2] == $past(i_control_wdata[5:2])) else $error("control readback");
  a_toggle_flip: assert property (i_control_wr && i_control_wdata.clock_toggle_strobe
    |=> o_serial_clock_level != $past(o_serial_clock_level)) else $error("no toggle");
  a_dout_none: assert property ((o_control.wire_mode != uss_pkg::WM_THREE)[*3]
    |-> !o_data_out) else $error("data out driven outside three-wire");
  a_dout_msb: assert property ((o_control.wire_mode == uss_pkg::WM_THREE
    && !o_control.external_clock_select && $stable(o_shift_data))[*3]
    |-> o_data_out == o_shift_data[DATA_W-1]) else $error("data out not msb");
  a_irq_level: assert property ((o_counter_overflow_flag && i_overflow_irq_en)[*2]
    |-> o_overflow_irq) else $error("overflow irq missing");
  // Main scenarios reached
  c_wrap: cover property ($rose(o_counter_overflow_flag));
  c_timer: cover property (i_timer0_match);
  c_toggle: cover property (i_control_wr && i_control_wdata.clock_toggle_strobe);
endmodule
`default_nettype wire

// ==== dv/uss_peer.sv ====
// Peer SPI master that clocks the link and swaps a byte
`default_nettype none
module uss_peer (
  output logic      o_clk,
  output logic      o_mosi,
  input  wire logic i_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sr;
  // Clock stands low between frames
  initial begin
    o_clk = 1'b0;
    o_mosi = 1'b0;
    sr = 8'h00;
  end
  // byte and first bit set up ahead
  task automatic load(input logic [7:0] b);
    sr = b;
    o_mosi = b[7];
  endtask
  // software pulses, ring shift, edge by polarity
  task automatic frame(input logic pol, input int n);
    #11.7;
    for (int i = 0; i < n; i++) begin
      #40 o_clk = 1'b1;
      if (pol) o_mosi = sr[7];
      else sr = {sr[6:0], i_miso};
      #40 o_clk = 1'b0;
      if (pol) sr = {sr[6:0], i_miso};
      else o_mosi = sr[7];
    end
  endtask
  // released line shows the inverse of its last level
  task automatic idle();
    #40 o_mosi = ~o_mosi;
  endtask
endmodule
`default_nettype wire

// ==== dv/uss_shift_unit_bench.sv ====
// Self-checking bench of the shift unit against a peer master
`default_nettype none
module uss_shift_unit_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LIMIT = 4000;
  logic clk = 1'b0, srst = 1'b1, tmr = 1'b0, oen = 1'b0;
  logic dwr = 1'b0, swr = 1'b0, cwr = 1'b0;
  logic [7:0] dwd = 8'h00, dv, rd, pb;
  uss_pkg::uss_status_t swd = '0, sv;
  uss_pkg::uss_ctrl_t cwd = '0, cv, oc;
  logic lclk, mosi, dout, lvl, flag, irq, sda, hold, sflag, sirq;
  logic [3:0] cnt;
  int mismatches = 0, num_checks = 0, cycles = 0;
  uss_shift_unit dut (
    .i_clk_sys(clk), .i_srst(srst), .i_clk_link(lclk), .i_serial_data_in(mosi),
    .i_timer0_match(tmr), .i_data_wr(dwr), .i_data_wdata(dwd), .i_status_wr(swr),
    .i_status_wdata(swd), .i_control_wr(cwr), .i_control_wdata(cwd),
    .i_overflow_irq_en(oen), .i_start_irq_en(1'b0), .o_shift_data(rd),
    .o_counter(cnt), .o_counter_overflow_flag(flag), .o_start_detect_flag(sflag),
    .o_control(oc), .o_data_out(dout), .o_sda_drive_low(sda), .o_serial_clock_level(lvl),
    .o_serial_clock_hold_low(hold), .o_overflow_irq(irq), .o_start_irq(sirq)
  );
  uss_peer peer (.o_clk(lclk), .o_mosi(mosi), .i_miso(dout));
  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One-cycle write pulse; the leading wait keeps two calls apart
  task automatic wr(input logic d, input logic s, input logic c);
    @(negedge clk);
    {dwr, swr, cwr} = {d, s, c};
    dwd = dv;
    swd = sv;
    cwd = cv;
    @(negedge clk);
    {dwr, swr, cwr} = 3'h0;
  endtask
  function automatic uss_pkg::uss_ctrl_t ctl(input logic [1:0] m, input logic [3:0] f);
    return {m, f};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    // Link side reset needs link edges both during and after the release
    fork
      begin
        cyc(40);
        srst = 1'b0;
      end
      peer.frame(1'b0, 5);
    join
    cyc(32);
    chk({rd, cnt, flag, dout, lvl, irq}, 16'h0000, "reset");
    chk(oc, 16'h0000, "ctl reset");
    cv = ctl(uss_pkg::WM_THREE, 4'h0);
    dv = 8'hff;
    wr(1, 0, 1);
    cyc(1);
    chk(dout, 1'b1, "msb out");
    cv = ctl(uss_pkg::WM_NONE, 4'h0);
    wr(0, 0, 1);
    cyc(2);
    chk(dout, 1'b0, "no mode");
    // Software strobe from fifteen wraps the counter
    cv = ctl(uss_pkg::WM_THREE, 4'h2);
    sv = '{1'b0, 1'b1, 4'hf};
    dv = 8'h81;
    wr(1, 1, 0);
    chk(cnt, 4'hf, "count load");
    wr(0, 0, 1);
    chk({rd, cnt, flag}, {7'h01, mosi, 4'h0, 1'b1}, "strobe wrap");
    sv = '{1'b0, 1'b1, 4'h0};
    wr(0, 1, 0);
    chk({cnt, flag}, 5'h00, "status clear");
    dv = 8'h3c;
    wr(1, 0, 1);
    chk(rd, 8'h3c, "data wins");
    cv = ctl(uss_pkg::WM_THREE, 4'h4);
    wr(0, 1, 1);
    @(negedge clk) tmr = 1'b1;
    @(negedge clk) tmr = 1'b0;
    chk({rd, cnt}, {7'h3c, mosi, 4'h1}, "timer");
    // A toggle counts when the master mode selects it
    cv = ctl(uss_pkg::WM_THREE, 4'hb);
    wr(0, 0, 1);
    chk({lvl, cnt}, 5'h12, "toggle count");
    wr(0, 1, 0);
    // Back-to-back toggle and toggle-plus-strobe writes
    @(negedge clk) cwr = 1'b1;
    for (int i = 0; i < 16; i++) begin
      cwd = ctl(uss_pkg::WM_THREE, {2'h0, i[0], 1'b1});
      @(negedge clk);
    end
    cwr = 1'b0;
    chk({rd, cnt, lvl}, {{8{mosi}}, 4'h8, 1'b1}, "fast master");
    // Slave byte exchange at polarity 0, then 1
    oen = 1'b1;
    for (int p = 0; p < 2; p++) begin
      cv = ctl(uss_pkg::WM_THREE, {1'b1, p[0], 2'h0});
      dv = p[0] ? 8'h96 : 8'ha5;
      pb = p[0] ? 8'hb5 : 8'hc3;
      wr(1, 1, 1);
      peer.load(pb);
      cyc(2);
      peer.frame(p[0], 1);
      cyc(10);
      chk({rd, cnt}, {dv[6:0], 1'b1, 4'h2}, "first bit");
      peer.frame(p[0], 7);
      peer.idle();
      cyc(10);
      chk({rd, cnt, flag, irq}, {pb, 4'h0, 2'h3}, "byte swap");
      chk(peer.sr, dv, "peer got");
    end
    oen = 1'b0;
    cyc(2);
    chk(irq, 1'b0, "irq masked");
    chk({sda, hold, sflag, sirq}, 16'h0000, "two-wire quiet");
    tally_and_finish();
  end
endmodule
bind uss_shift_unit uss_chk #(.DATA_W(DATA_W), .CNT_W(CNT_W)) u_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_timer0_match(i_timer0_match),
  .i_data_wr(i_data_wr), .i_data_wdata(i_data_wdata), .i_status_wr(i_status_wr),
  .i_status_wdata(i_status_wdata), .i_control_wr(i_control_wr),
  .i_control_wdata(i_control_wdata), .i_overflow_irq_en(i_overflow_irq_en),
  .o_shift_data(o_shift_data), .o_counter(o_counter),
  .o_counter_overflow_flag(o_counter_overflow_flag), .o_control(o_control),
  .o_data_out(o_data_out), .o_serial_clock_level(o_serial_clock_level),
  .o_overflow_irq(o_overflow_irq)
);
`default_nettype wire

// ==== src/uss_pkg.sv ====
// Shared types and constants of the universal shift unit
//
// Behaviour
// RULE1: Eight-bit shift register, CPU read/write, no receive buffer.
// RULE2: Shift register MSB drives one of two output pins by wire mode.
// RULE3: Output latch makes output change on edge opposite to sampling.
// RULE4: Serial input always comes from the data input pin.
// RULE5: Four-bit counter, CPU read/write, sets overflow flag on wrap.
// RULE6: Shift register and counter clocked together by one source; external toggle mode shifts on the pin and counts toggle strobes.
// RULE7: External clock counts both rising and falling edges.
// RULE8: Clock source is pin, timer compare match or software strobe.
// RULE9: Two-wire start flag, optional interrupt, clock held low as wait.
// RULE10: Three-wire mode follows data modes 0 and 1, no slave select.
// RULE11: Two linked units form a ring; eight clocks swap both bytes.
// RULE12: Master generates serial clock by software toggling.
// RULE13: Polarity 0 samples on rising, shifts on falling; 1 is opposite.
// RULE14: Software loads data and enables driver half a clock early.
// RULE15: Software clears counter before each byte.
// RULE16: External clock: sixteen edges overflow counter and set flag.
// RULE17: Counter overflow interrupt can wake processor from idle.
// RULE18: Software processes the byte before next transfer.
// RULE19: Status write with flag one and count zero clears both.
// RULE20: Low wire-mode bit selects three-wire; external polarity 0 is slave. The code takes three-wire for wire mode 01 only; 11 is two-wire hold.
// RULE21: Alternating toggle and toggle-plus-strobe writes give fck/4 master clock; back-to-back writes here give fck/2.
// RULE22: Latch open in first half cycle externally, always open internally.
// RULE23: Data write in a shift cycle keeps written value, no shift.
// RULE24: Reset clears data, counter, flags and control; no wire mode.
// RULE25: Each toggle strobe inverts clock pin once, counts in strobe mode.
`default_nettype none

package uss_pkg;

  // ==========================================================================
  // Sizes
  localparam int DATA_W = 8;
  localparam int CNT_W  = 4;

  // ==========================================================================
  // Wire modes
  localparam logic [1:0] WM_NONE     = 2'h0;
  localparam logic [1:0] WM_THREE    = 2'h1;
  localparam logic [1:0] WM_TWO      = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  // ==========================================================================
  // Reset values and counter step and limit
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 4'h1;
  localparam logic [CNT_W-1:0]  CNT_MAX  = 4'hf;

  // ==========================================================================
  // Control word as written and read back; strobes always read as zero
  typedef struct packed {
    logic [1:0] wire_mode;
    logic       external_clock_select;
    logic       clock_polarity_select;
    logic       shift_clock_strobe;
    logic       clock_toggle_strobe;
  } uss_ctrl_t;

  localparam uss_ctrl_t CTRL_RST = '{default: 1'b0};

  // Status write: a one clears the flag, the count is loaded
  typedef struct packed {
    logic             start_detect_flag;
    logic             counter_overflow_flag;
    logic [CNT_W-1:0] count;
  } uss_status_t;

  // Decoded shift clock source
  typedef enum logic [2:0] {
    SRC_NONE,
    SRC_SOFT,
    SRC_TIMER,
    SRC_EXT_EDGES,
    SRC_EXT_TOGGLE
  } uss_src_t;

endpackage

`default_nettype wire

// ==== src/uss_shift_unit.sv ====
// Universal shift unit: shift register, edge counter, clock select, pins
`default_nettype none

module uss_shift_unit #(
  parameter int DATA_W = uss_pkg::DATA_W,
  parameter int CNT_W  = uss_pkg::CNT_W
) (
  input  wire logic                i_clk_sys,
  input  wire logic                i_srst,
  input  wire logic                i_clk_link,
  input  wire logic                i_serial_data_in,
  input  wire logic                i_timer0_match,
  input  wire logic                i_data_wr,
  input  wire logic [DATA_W-1:0]   i_data_wdata,
  input  wire logic                i_status_wr,
  input  wire uss_pkg::uss_status_t i_status_wdata,
  input  wire logic                i_control_wr,
  input  wire uss_pkg::uss_ctrl_t  i_control_wdata,
  input  wire logic                i_overflow_irq_en,
  input  wire logic                i_start_irq_en,
  output logic [DATA_W-1:0]        o_shift_data,
  output logic [CNT_W-1:0]         o_counter,
  output logic                     o_counter_overflow_flag,
  output logic                     o_start_detect_flag,
  output uss_pkg::uss_ctrl_t       o_control,
  output logic                     o_data_out,
  output logic                     o_sda_drive_low,
  output logic                     o_serial_clock_level,
  output logic                     o_serial_clock_hold_low,
  output logic                     o_overflow_irq,
  output logic                     o_start_irq
);

  // ==========================================================================
  // Elaboration checks
  // The package fixes the field widths of the carriers, so only the
  // documented sizes can be served.
  if (DATA_W != uss_pkg::DATA_W) begin : g_bad_data_w
    $error("DATA_W must match the package data width");
  end
  if (CNT_W != uss_pkg::CNT_W) begin : g_bad_cnt_w
    $error("CNT_W must match the package counter width");
  end

  // ==========================================================================
  // Link clock domain
  // A rising edge flips the rise toggle and a falling edge copies it; each samples the data pin
  // in the same flop, so the sampled bit is stable for a full period
  // while the toggle crosses into the system domain.

  typedef struct packed {
    logic rst1;
    logic rst2;
    logic tog;
    logic bit_in;
  } uss_rise_t;

  typedef struct packed {
    logic tog;
    logic bit_in;
  } uss_fall_t;

  uss_rise_t rise_q;
  uss_rise_t rise_d;
  uss_fall_t fall_q;
  uss_fall_t fall_d;

  // Rising edge side, also carries the reset into the link domain
  always_comb begin
    rise_d      = rise_q;
    rise_d.rst1 = i_srst;
    rise_d.rst2 = rise_q.rst1;
    if (rise_q.rst2) begin
      rise_d.tog    = 1'b0;
      rise_d.bit_in = 1'b0;
    end else begin
      rise_d.tog    = ~rise_q.tog;
      // RULE4: sample data pin
      rise_d.bit_in = i_serial_data_in;
    end
  end

  // Rising edge register; the reset stages are plain flops by design
  always_ff @(posedge i_clk_link) begin
    rise_q <= rise_d;
  end

  // Falling edge side
  always_comb begin
    fall_d = fall_q;
    if (rise_q.rst2) begin
      fall_d.tog    = 1'b0;
      fall_d.bit_in = 1'b0;
    end else begin
      // Copy the rise toggle: a fall with no counted rise is no edge
      fall_d.tog    = rise_q.tog;
      // RULE4: sample data pin
      fall_d.bit_in = i_serial_data_in;
    end
  end

  // Falling edge register
  always_ff @(negedge i_clk_link) begin
    fall_q <= fall_d;
  end

  // ==========================================================================
  // Crossings into the system domain

  logic di_lvl;
  logic di_chg;
  logic rise_lvl;
  logic rise_chg;
  logic fall_lvl;
  logic fall_chg;

  // Data pin level for internal clock sources and start detection
  uss_sync3 u_sync_di (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (i_serial_data_in),
    .o_level   (di_lvl),
    .o_change  (di_chg)
  );

  // Rising edge events
  uss_sync3 u_sync_rise (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (rise_q.tog),
    .o_level   (rise_lvl),
    .o_change  (rise_chg)
  );

  // Falling edge events
  uss_sync3 u_sync_fall (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_async   (fall_q.tog),
    .o_level   (fall_lvl),
    .o_change  (fall_chg)
  );

  // ==========================================================================
  // Clock source decode

  function automatic uss_pkg::uss_src_t decode_src(input uss_pkg::uss_ctrl_t c);
    uss_pkg::uss_src_t s;
    s = uss_pkg::SRC_NONE;
    if (c.external_clock_select) begin
      s = c.shift_clock_strobe ? uss_pkg::SRC_EXT_TOGGLE : uss_pkg::SRC_EXT_EDGES;
    end else if (c.clock_polarity_select) begin
      s = uss_pkg::SRC_TIMER;
    end else if (c.shift_clock_strobe) begin
      s = uss_pkg::SRC_SOFT;
    end
    return s;
  endfunction

  // ==========================================================================
  // System domain state

  typedef struct packed {
    logic [DATA_W-1:0]  sr;
    logic [CNT_W-1:0]   cnt;
    logic               ovf;
    logic               start;
    uss_pkg::uss_ctrl_t ctrl;
    logic               latch;
    logic               data_out;
    logic               sda_low;
    logic               clk_out;
    logic               hold;
    logic               ovf_irq;
    logic               start_irq;
  } uss_state_t;

  uss_state_t st_q;
  uss_state_t st_d;

  uss_pkg::uss_ctrl_t eff_ctrl;
  uss_pkg::uss_src_t  src;
  logic               scl_lvl;
  logic               shift_ev;
  logic               count_ev;
  logic               shift_bit;
  logic               wrap;
  logic               two_wire;
  logic               start_det;
  logic               latch_open;

  // Control in force this cycle; a control write acts at once
  always_comb begin
    eff_ctrl = i_control_wr ? i_control_wdata : st_q.ctrl;
    src      = decode_src(eff_ctrl);
    // Pin level follows from the two toggles: they differ after a rise
    scl_lvl  = rise_lvl ^ fall_lvl;
    two_wire = st_q.ctrl.wire_mode[1];
  end

  // Shift and count events from the selected source
  always_comb begin
    shift_ev  = 1'b0;
    count_ev  = 1'b0;
    shift_bit = di_lvl;
    // RULE8: three clock sources
    case (src)
      uss_pkg::SRC_SOFT: begin
        // RULE6: strobe clocks both
        shift_ev = i_control_wr & i_control_wdata.shift_clock_strobe;
        count_ev = shift_ev;
      end
      uss_pkg::SRC_TIMER: begin
        // RULE6: timer clocks both
        shift_ev = i_timer0_match;
        count_ev = i_timer0_match;
      end
      uss_pkg::SRC_EXT_EDGES: begin
        // RULE13: polarity picks sampling edge
        shift_ev  = eff_ctrl.clock_polarity_select ? fall_chg : rise_chg;
        shift_bit = eff_ctrl.clock_polarity_select ? fall_q.bit_in : rise_q.bit_in;
        // RULE7: count every edge
        count_ev  = rise_chg | fall_chg;
      end
      uss_pkg::SRC_EXT_TOGGLE: begin
        // RULE20: pin edge shifts data
        shift_ev  = eff_ctrl.clock_polarity_select ? fall_chg : rise_chg;
        shift_bit = eff_ctrl.clock_polarity_select ? fall_q.bit_in : rise_q.bit_in;
        // RULE25: toggle strobe counts
        count_ev  = i_control_wr & i_control_wdata.clock_toggle_strobe;
      end
      default: begin
        shift_ev = 1'b0;
        count_ev = 1'b0;
      end
    endcase
  end

  // Start condition: data falls while clock is high, two-wire only
  always_comb begin
    // RULE9: start detection
    start_det  = two_wire & di_chg & ~di_lvl & scl_lvl;
    wrap       = count_ev & (st_q.cnt == uss_pkg::CNT_MAX);
    // RULE22: latch open half cycle
    latch_open = ~st_q.ctrl.external_clock_select
               | (scl_lvl == st_q.ctrl.clock_polarity_select);
  end

  // Next state
  always_comb begin
    st_d = st_q;

    // RULE23: write beats shift
    if (i_data_wr) begin
      st_d.sr = i_data_wdata;
    end else if (shift_ev) begin
      // RULE1: shift left, MSB first
      st_d.sr = {st_q.sr[DATA_W-2:0], shift_bit};
    end

    // RULE5: counter load or step
    if (i_status_wr) begin
      st_d.cnt = i_status_wdata.count;
    end else if (count_ev) begin
      st_d.cnt = st_q.cnt + uss_pkg::CNT_ONE;
    end

    // RULE19: write one clears flag
    if (i_status_wr && i_status_wdata.counter_overflow_flag) begin
      st_d.ovf = 1'b0;
    end
    // RULE16: wrap sets flag, set wins
    if (wrap) begin
      st_d.ovf = 1'b1;
    end

    if (i_status_wr && i_status_wdata.start_detect_flag) begin
      st_d.start = 1'b0;
    end
    // RULE9: start flag, set wins
    if (start_det) begin
      st_d.start = 1'b1;
    end

    // Strobes act once and are never stored
    if (i_control_wr) begin
      st_d.ctrl                     = i_control_wdata;
      st_d.ctrl.shift_clock_strobe  = 1'b0;
      st_d.ctrl.clock_toggle_strobe = 1'b0;
    end

    // RULE25: toggle inverts clock pin
    // RULE21: paired writes on successive cycles give fck/2
    if (i_control_wr && i_control_wdata.clock_toggle_strobe) begin
      st_d.clk_out = ~st_q.clk_out;
    end

    // RULE3: latch holds MSB
    if (latch_open) begin
      st_d.latch = st_q.sr[DATA_W-1];
    end

    // RULE2: MSB routed by wire mode
    // RULE10: three-wire data output
    st_d.data_out = (st_d.ctrl.wire_mode == uss_pkg::WM_THREE) & st_d.latch;
    st_d.sda_low  = st_d.ctrl.wire_mode[1] & ~st_d.latch;

    // RULE9: wait state holds clock low
    st_d.hold = st_d.ctrl.wire_mode[1]
              & ((st_d.start & ~scl_lvl)
              | ((st_d.ctrl.wire_mode == uss_pkg::WM_TWO_HOLD) & st_d.ovf));

    // RULE17: overflow interrupt wakes idle
    st_d.ovf_irq   = st_d.ovf & i_overflow_irq_en;
    st_d.start_irq = st_d.start & i_start_irq_en;
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      // RULE24: clear everything
      st_q           <= '{default: 1'b0};
      st_q.sr        <= uss_pkg::DATA_RST;
      st_q.cnt       <= uss_pkg::CNT_RST;
      st_q.ctrl      <= uss_pkg::CTRL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs, each straight from the state register
  // RULE11: data out and data in close the ring
  assign o_shift_data            = st_q.sr;
  assign o_counter               = st_q.cnt;
  assign o_counter_overflow_flag = st_q.ovf;
  assign o_start_detect_flag     = st_q.start;
  assign o_control               = st_q.ctrl;
  assign o_data_out              = st_q.data_out;
  assign o_sda_drive_low         = st_q.sda_low;
  assign o_serial_clock_level    = st_q.clk_out;
  assign o_serial_clock_hold_low = st_q.hold;
  assign o_overflow_irq          = st_q.ovf_irq;
  assign o_start_irq             = st_q.start_irq;

endmodule

`default_nettype wire

// ==== src/uss_sync3.sv ====
// Three-stage input synchroniser with agreement filter and change pulse
`default_nettype none

module uss_sync3 (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  input  wire logic i_async,
  output logic      o_level,
  output logic      o_change
);

  typedef struct packed {
    logic q1;
    logic q2;
    logic q3;
    logic lvl;
    logic chg;
  } uss_sync_t;

  uss_sync_t st_q;
  uss_sync_t st_d;

  // Level is accepted only once stages two and three agree
  always_comb begin
    st_d     = st_q;
    st_d.q1  = i_async;
    st_d.q2  = st_q.q1;
    st_d.q3  = st_q.q2;
    st_d.chg = 1'b0;
    if ((st_q.q2 == st_q.q3) && (st_q.q3 != st_q.lvl)) begin
      st_d.lvl = st_q.q3;
      st_d.chg = 1'b1;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_q <= '{default: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level  = st_q.lvl;
  assign o_change = st_q.chg;

endmodule

`default_nettype wire
